// ---- rtl/trtb_bridge.sv ----
// transport remote tally bridge: console switch closures to command
// messages, master status back to tallies, tach and direction.
// assumes inputs synchronous to clk_sys_in and a message sink with ready.
// Overview of operation
// [R1] Five switch closures are taken, one each for rewind, fast forward, stop, play, record.
// [R2] Each new closure forms a command message handed to the main processor; a repeat of a command still pending merges into one message.
// [R3] Every message carries the currently designated master machine as its address.
// [R4] One tally output per transport mode is driven back to the console connector.
// [R5] Tallies follow the status reported by the master, never the command inputs.
// [R6] Tach and direction come from master data with rate and polarity independent of type.
// [R7] Tach gives 30 pulses per second at play speed, 25 in the European standard.
// [R8] Direction is high for the standardized (forward) sense.
// [R9] Any one of five machines may be selected as master for commands and returned data.
// [R10] Tach rate scales with reported speed and stops when the master is stationary.
`timescale 1ns/100ps
`default_nettype none

module trtb_bridge
   import trtb_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    resetn_in,
   // console transport connector
   input  wire logic [NUM_CMD-1:0]      cmd_close_in,
   output var  logic [NUM_CMD-1:0]      tally_out,
   output var  logic                    tach_out,
   output var  logic                    dir_out,
   // configuration
   input  wire logic [2:0]              master_sel_in,
   input  wire logic                    ebu_in,
   // status from all machines
   input  wire trtb_status_t            mach_status_in [NUM_MACH],
   // message path to the main processor
   output var  logic                    msg_valid_out,
   output var  trtb_msg_t               msg_out,
   input  wire logic                    msg_ready_in
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;

   // two flops so release is clean to the clock
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // master selection
   // ----------------------------------------------------------------
   logic [2:0] master_reg;
   logic [2:0] master_next;

   // out-of-range selections are ignored, keeping the last legal master
   always_comb begin
      master_next = master_reg;
      if (master_sel_in < 3'(NUM_MACH)) begin
         master_next = master_sel_in; // R9
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         master_reg <= MASTER_RST;
      end else begin
         master_reg <= master_next;
      end
   end

   // ----------------------------------------------------------------
   // command capture and message issue
   // ----------------------------------------------------------------
   logic [NUM_CMD-1:0] close_prev_reg;
   logic [NUM_CMD-1:0] close_prev_next;
   logic [NUM_CMD-1:0] pend_reg;
   logic [NUM_CMD-1:0] pend_next;
   logic               msg_valid_reg;
   logic               msg_valid_next;
   trtb_msg_t          msg_reg;
   trtb_msg_t          msg_next;
   logic [NUM_CMD-1:0] rise;
   logic [NUM_CMD-1:0] pick;

   // rising edges of closures; one pending bit per command, so a press
   // during a stalled message is held, not lost (set wins over clear)
   generate
      for (genvar i = 0; i < NUM_CMD; i++) begin : g_rise
         assign rise[i] = cmd_close_in[i] & ~close_prev_reg[i]; // R1
      end
   endgenerate

   always_comb begin
      close_prev_next = cmd_close_in;
      pend_next       = pend_reg;
      msg_valid_next  = msg_valid_reg;
      msg_next        = msg_reg;
      pick            = '0;
      if (msg_valid_reg && msg_ready_in) begin
         msg_valid_next = 1'b0;
      end
      // lowest index wins when several commands wait
      if (!msg_valid_next) begin
         for (int k = NUM_CMD - 1; k >= 0; k--) begin
            if (pend_reg[k]) begin
               pick = '0;
               pick[k] = 1'b1;
            end
         end
         for (int k = 0; k < NUM_CMD; k++) begin
            if (pick[k]) begin
               msg_valid_next = 1'b1;                  // R2
               msg_next.cmd   = trtb_cmd_t'(3'(k));
               msg_next.machine = master_reg;          // R3
            end
         end
      end
      pend_next = (pend_reg & ~pick) | rise;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         close_prev_reg <= '0;
         pend_reg       <= '0;
         msg_valid_reg  <= 1'b0;
         msg_reg        <= '0;
      end else begin
         close_prev_reg <= close_prev_next;
         pend_reg       <= pend_next;
         msg_valid_reg  <= msg_valid_next;
         msg_reg        <= msg_next;
      end
   end

   assign msg_valid_out = msg_valid_reg;
   assign msg_out       = msg_reg;

   // ----------------------------------------------------------------
   // tally, direction and tach from master status
   // ----------------------------------------------------------------
   trtb_status_t        mstat;
   logic [NUM_CMD-1:0]  tally_reg;
   logic [NUM_CMD-1:0]  tally_next;
   logic                dir_reg;
   logic                dir_next;
   logic                tach_reg;
   logic                tach_next;
   logic [ACC_W-1:0]    acc_reg;
   logic [ACC_W-1:0]    acc_next;
   logic [ACC_W-1:0]    period;
   logic [ACC_W-1:0]    step;

   assign mstat  = mach_status_in[master_reg];                   // R9
   assign period = ebu_in ? ACC_W'(TACH_CYC_EBU) : ACC_W'(TACH_CYC_NTSC); // R7
   assign step   = ACC_W'(mstat.speed);                           // R10

   // phase accumulator: adds speed (play = 256) each cycle and wraps at
   // period*256, so the pulse rate is exact at play speed and scales linearly
   always_comb begin
      tally_next = mstat.mode;                                    // R5
      dir_next   = ~mstat.reverse;                                // R8
      acc_next   = acc_reg;
      tach_next  = tach_reg;
      if (mstat.speed == '0) begin
         tach_next = 1'b0;                                        // R10
      end else begin
         if (acc_reg + step >= (period << 8)) begin
            acc_next = acc_reg + step - (period << 8);            // R6
         end else begin
            acc_next = acc_reg + step;
         end
         tach_next = (acc_next < (period << 7));                  // R7
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tally_reg <= TALLY_RST;
         dir_reg   <= 1'b1;
         tach_reg  <= 1'b0;
         acc_reg   <= '0;
      end else begin
         tally_reg <= tally_next;
         dir_reg   <= dir_next;
         tach_reg  <= tach_next;
         acc_reg   <= acc_next;
      end
   end

   assign tally_out = tally_reg; // R4
   assign dir_out   = dir_reg;
   assign tach_out  = tach_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_tally_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R5
      $past(rst_n_reg) |-> tally_out == $past(mach_status_in[master_reg].mode))
      else $error("tally does not follow master mode");

   chk_dir_polarity: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R8
      $past(rst_n_reg) |-> dir_out == ~$past(mach_status_in[master_reg].reverse))
      else $error("direction polarity wrong");

   chk_msg_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R3
      $rose(msg_valid_out) |-> msg_out.machine == $past(master_reg))
      else $error("message addressed to wrong machine");

   chk_msg_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R2
      msg_valid_out && !msg_ready_in |=> msg_valid_out && $stable(msg_out))
      else $error("message dropped before accepted");

   chk_press_issue: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R1
      rise[0] && !msg_valid_out && pend_reg == '0
      |-> ##2 msg_valid_out && msg_out.cmd == TRTB_CMD_REWIND)
      else $error("rewind press did not issue");

   chk_tach_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R10
      mstat.speed == '0 |=> !tach_out)
      else $error("tach runs while stationary");

   chk_master_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R9
      master_reg < 3'(NUM_MACH))
      else $error("master out of range");

   chk_acc_bound: assert property (@(posedge clk_sys_in) disable iff (!rst_n_reg) // R7
      acc_reg < (period << 8) || $changed(ebu_in) || $past(ebu_in) != ebu_in)
      else $error("tach phase exceeds period");

endmodule

`default_nettype wire

// ---- rtl/trtb_pkg.sv ----
// package for the transport remote tally bridge
// assumes a single 40 MHz system clock and one consumer of command messages
package trtb_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 40000000;
   localparam int unsigned TACH_PPS_NTSC  = 30;
   localparam int unsigned TACH_PPS_EBU   = 25;
   // cycles between tach pulses at play speed
   localparam int unsigned TACH_CYC_NTSC  = CLK_HZ / TACH_PPS_NTSC;
   localparam int unsigned TACH_CYC_EBU   = CLK_HZ / TACH_PPS_EBU;
   localparam int unsigned TACH_HIGH_CYC  = TACH_CYC_EBU / 2;
   // speed is a fraction of play speed, 8 fractional bits
   localparam int unsigned SPEED_W        = 12;
   localparam logic [11:0] SPEED_PLAY     = 12'h100;
   localparam int unsigned ACC_W          = 32;

   // ----------------------------------------------------------------
   // commands, modes and reset values
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CMD        = 5;
   localparam int unsigned NUM_MACH       = 5;
   localparam logic [2:0]  MASTER_RST     = 3'h0;
   localparam logic [4:0]  TALLY_RST      = 5'h00;

   typedef enum logic [2:0] {
      TRTB_CMD_REWIND  = 3'h0,
      TRTB_CMD_FFWD    = 3'h1,
      TRTB_CMD_STOP    = 3'h2,
      TRTB_CMD_PLAY    = 3'h3,
      TRTB_CMD_RECORD  = 3'h4
   } trtb_cmd_t;

   // message to the main processor
   typedef struct packed {
      logic [2:0] machine;
      trtb_cmd_t  cmd;
   } trtb_msg_t;

   // status reported by the master machine module
   typedef struct packed {
      logic [4:0]         mode;
      logic               reverse;
      logic [SPEED_W-1:0] speed;
   } trtb_status_t;

endpackage

// ---- sim/tb.sv ----
// self-checking bench for the transport remote tally bridge
// assumes the console model and a message sink played by the bench
`timescale 1ns/100ps
`default_nettype none

module tb
   import trtb_pkg::*;
;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic               clk_sys_in = 1'b0;
   logic               resetn_in  = 1'b0;
   logic [4:0]         cmd_close;
   logic [4:0]         tally;
   logic               tach;
   logic               dir;
   logic [2:0]         master_sel = 3'h0;
   logic               ebu        = 1'b0;
   trtb_status_t       mach_st [NUM_MACH];
   logic               msg_valid;
   trtb_msg_t          msg;
   logic               msg_ready  = 1'b0;
   int                 fails       = 0;
   int                 comparisons = 0;
   int                 cyc         = 0;

   trtb_console_model i_panel (
      .clk_sys_in (clk_sys_in),
      .close_out  (cmd_close)
   );

   trtb_bridge i_dut (
      .clk_sys_in     (clk_sys_in),
      .resetn_in      (resetn_in),
      .cmd_close_in   (cmd_close),
      .tally_out      (tally),
      .tach_out       (tach),
      .dir_out        (dir),
      .master_sel_in  (master_sel),
      .ebu_in         (ebu),
      .mach_status_in (mach_st),
      .msg_valid_out  (msg_valid),
      .msg_out        (msg),
      .msg_ready_in   (msg_ready)
   );

   // -------------------------------------------------------------
   // clock, status and hang guard
   // -------------------------------------------------------------
   initial begin
      for (int i = 0; i < NUM_MACH; i++) begin
         mach_st[i] = {5'(1 << i), 1'(i % 2), 12'h000};
      end
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   // two tach half periods (about 91700 cycles) dominate the run
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 95000) begin
         fails++;
         end_sim();
      end
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // waits for a message, stalls the sink, then accepts it
   task automatic get_msg(input int c, input int stall);
      int n;
      n = 0;
      while (msg_valid !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      tick(stall);
      cmp(16'(msg_valid), 16'h0001);
      cmp(16'(msg), 16'({master_sel, 3'(c)}));
      msg_ready = 1'b1;
      tick(1);
      msg_ready = 1'b0;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic test_tally;
      for (int m = 0; m < NUM_MACH; m++) begin
         master_sel = 3'(m);
         tick(3);
         cmp(16'(tally), 16'(mach_st[m].mode));
         cmp(16'(dir), {15'h0000, ~mach_st[m].reverse});
      end
      master_sel = 3'h7;
      tick(3);
      cmp(16'(tally), 16'(mach_st[4].mode));
      $display("test tally done");
   endtask

   task automatic test_cmds;
      for (int c = 0; c < NUM_CMD; c++) begin
         master_sel = 3'(4 - c);
         i_panel.press(5'(1 << c));
         cmp(16'(tally), 16'(mach_st[4 - c].mode));
         get_msg(c, c);
      end
      i_panel.press(5'h1F);
      for (int c = 0; c < NUM_CMD; c++) begin
         get_msg(c, 0);
      end
      // stop pressed twice behind a stalled rewind merges into one message
      i_panel.press(5'h01);
      i_panel.press(5'h04);
      i_panel.press(5'h04);
      get_msg(0, 0);
      get_msg(2, 0);
      tick(3);
      cmp(16'(msg_valid), 16'h0000);
      $display("test commands done");
   endtask

   // times the high half at full speed from a phase that must be clear;
   // a half period at full speed is the shortest count worth timing
   task automatic tach_high(input longint exp);
      int n;
      n = 0;
      mach_st[0].speed = 12'hFFF;
      tick(1);
      while (tach === 1'b1 && n < 55000) begin
         tick(1);
         n++;
      end
      cmp(16'(n >= exp - 2 && n <= exp + 2), 16'h0001);
      mach_st[0].speed = 12'h000;
      tick(3);
      cmp(16'(tach), 16'h0000);
   endtask

   // one run per frame standard; a mid-run reset clears the phase between
   task automatic test_tach;
      master_sel = 3'h0;
      tach_high(longint'(TACH_CYC_NTSC) * 128 / 4095);
      resetn_in = 1'b0;
      tick(2);
      cmp(16'({tally, tach, dir, msg_valid}), 16'h0002);
      ebu       = 1'b1;
      resetn_in = 1'b1;
      tick(3);
      tach_high(longint'(TACH_CYC_EBU) * 128 / 4095);
      $display("test tach done");
   endtask

   task automatic end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      tick(4);
      cmp(16'({tally, tach, dir, msg_valid}), 16'h0002);
      resetn_in = 1'b1;
      tick(3);
      test_tally();
      test_cmds();
      test_tach();
      end_sim();
   end
endmodule

`default_nettype wire

// ---- sim/trtb_console_model.sv ----
// console panel model: remote push buttons as switch closures
// assumes the caller enters press just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none

module trtb_console_model
   import trtb_pkg::*;
(
   // clock
   input  wire logic               clk_sys_in,
   // console transport connector
   output var  logic [NUM_CMD-1:0] close_out
);
   // -------------------------------------------------------------
   // button closures
   // -------------------------------------------------------------
   initial close_out = '0;

   // a press stays shut for four cycles, as a finger would, then opens
   // for one so that the next press is seen as a fresh closure
   task automatic press(input logic [NUM_CMD-1:0] mask);
      close_out = mask;
      repeat (4) @(posedge clk_sys_in);
      #1;
      close_out = '0;
      @(posedge clk_sys_in);
      #1;
   endtask
endmodule

`default_nettype wire
